/* File: t2cl_pkg.sv */
// constants, offsets and field positions for the timer two control logic
// Summary of operation
// - overflow sets overflow_flag unless baud source
// - enabled trigger capture/reload sets external_event_flag
// - external_event_flag with enable requests interrupt
// - up_down_enable set masks external flag interrupt
// - receive baud from timer one or ours
// - transmit baud from timer one or ours
// - trigger ignored unless enabled and not baud
// - run_control stops or starts counting
// - count internal tick or count pin falls
// - baud mode forces reload, ignores capture select
// - select reload on overflow or capture on trigger
// - control clears on reset, bitwise set/clear
package t2cl_pkg;
   localparam int AW = 8;
   localparam int DW = 8;
   // register offsets
   localparam logic [7:0] OFS_CTRL     = 8'hC8;
   localparam logic [7:0] OFS_MODE     = 8'hC9;
   localparam logic [7:0] OFS_CNT_LO   = 8'hCA;
   localparam logic [7:0] OFS_CNT_HI   = 8'hCB;
   localparam logic [7:0] OFS_CAP_LO   = 8'hCC;
   localparam logic [7:0] OFS_CAP_HI   = 8'hCD;
   localparam logic [7:0] OFS_CTRL_SET = 8'hCE;
   localparam logic [7:0] OFS_CTRL_CLR = 8'hCF;
   localparam logic [7:0] OFS_IRQ_STAT = 8'hD0;
   localparam logic [7:0] OFS_IRQ_EN   = 8'hD1;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'hD2;
   // control field positions
   localparam int B_OVF   = 7;
   localparam int B_EXF   = 6;
   localparam int B_RXSEL = 5;
   localparam int B_TXSEL = 4;
   localparam int B_EXEN  = 3;
   localparam int B_RUN   = 2;
   localparam int B_CSEL  = 1;
   localparam int B_CPRL  = 0;
   // mode field positions
   localparam int B_CLKOE = 1;
   localparam int B_UDEN  = 0;
   // interrupt status positions
   localparam int I_OVF   = 0;
   localparam int I_EXF   = 1;
   // reset values
   localparam logic [7:0]  CTRL_RST = 8'h00;
   localparam logic [7:0]  MODE_RST = 8'h00;
   localparam logic [15:0] CNT_RST  = 16'h0000;
   localparam logic [7:0]  RD_IDLE  = 8'h00;
   localparam logic [15:0] CNT_MAX  = 16'hFFFF;
   // core clocks per internal count tick: timer mode and baud mode
   localparam logic [3:0]  DIV_TIMER = 4'hC;
   localparam logic [3:0]  DIV_BAUD  = 4'h2;
   // serial modes that take a baud tick
   localparam logic [1:0]  SMODE_1 = 2'h1;
   localparam logic [1:0]  SMODE_3 = 2'h3;
   // counter sequencer states
   typedef enum logic [2:0] {
      T2CL_IDLE   = 3'b001,
      T2CL_COUNT  = 3'b010,
      T2CL_BAUD   = 3'b100
   } t2cl_state_t;
endpackage

/* File: t2cl_edge.sv */
// falling edge detector for a synchronous pin
module t2cl_edge
   import t2cl_pkg::*;
(
   input  wire logic core_clk_i,   // core clock
   input  wire logic rst_i,        // async reset, high
   input  wire logic pin_i,        // sampled pin
   output logic      fall_o        // one-cycle pulse on 1 to 0
);
   logic prev_q;

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prev_q <= 1'b1;
         fall_o <= 1'b0;
      end
      else
      begin
         prev_q <= pin_i;
         fall_o <= prev_q & ~pin_i;
      end
   end
endmodule

/* File: t2cl_prescale.sv */
// divider giving one-cycle count enables from the core clock
module t2cl_prescale
   import t2cl_pkg::*;
(
   input  wire logic       core_clk_i,  // core clock
   input  wire logic       rst_i,       // async reset, high
   input  wire logic       run_i,       // divider runs
   input  wire logic [3:0] div_i,       // clocks per tick
   output logic            tick_o       // one-cycle enable
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   wire        wrap = (cnt_q >= div_i - 4'h1);

   assign cnt_d = (!run_i || wrap) ? 4'h0 : cnt_q + 4'h1;

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_q  <= 4'h0;
         tick_o <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         tick_o <= run_i & wrap;
      end
   end
endmodule

/* File: t2cl_timer2.sv */
// timer two control, status, counter and baud source logic
module t2cl_timer2
   import t2cl_pkg::*;
(
   input  wire logic          core_clk_i,   // core clock, 50 MHz
   input  wire logic          rst_i,        // async reset, high
   input  wire logic [AW-1:0] addr_i,       // register address
   input  wire logic [DW-1:0] wdata_i,      // write data
   input  wire logic          wr_i,         // write strobe
   input  wire logic          rd_i,         // read strobe
   output logic      [DW-1:0] rdata_o,      // read data, cycle after rd_i
   input  wire logic          count_input_pin_i,        // external count pin
   input  wire logic          external_trigger_pin_i,   // external trigger pin
   input  wire logic          t1_ovf_i,     // timer one overflow pulse
   input  wire logic [1:0]    serial_mode_i,// serial port mode
   input  wire logic          timer_int_en_i,// timer interrupt enable
   output logic              rx_baud_o,    // receive baud pulse
   output logic              tx_baud_o,    // transmit baud pulse
   output logic              timer_irq_o,  // timer interrupt request
   output logic              irq_o         // level interrupt
);
   // sticky set-over-clear
   function automatic logic sticky(input logic cur, input logic set, input logic clr);
      sticky = set | (cur & ~clr);
   endfunction

   // register state
   logic [7:0]  ctrl_q;
   logic [7:0]  ctrl_d;
   logic [1:0]  mode_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] cap_q;
   logic [15:0] cap_d;
   logic [1:0]  istat_q;
   logic [1:0]  istat_d;
   logic [1:0]  ien_q;
   t2cl_state_t state_q;
   t2cl_state_t state_d;

   // bus decode
   wire wr_ctrl   = wr_i && (addr_i == OFS_CTRL);
   wire wr_mode   = wr_i && (addr_i == OFS_MODE);
   wire wr_cnt_lo = wr_i && (addr_i == OFS_CNT_LO);
   wire wr_cnt_hi = wr_i && (addr_i == OFS_CNT_HI);
   wire wr_cap_lo = wr_i && (addr_i == OFS_CAP_LO);
   wire wr_cap_hi = wr_i && (addr_i == OFS_CAP_HI);
   wire wr_set    = wr_i && (addr_i == OFS_CTRL_SET);
   wire wr_clr    = wr_i && (addr_i == OFS_CTRL_CLR);
   wire wr_ien    = wr_i && (addr_i == OFS_IRQ_EN);
   wire wr_iclr   = wr_i && (addr_i == OFS_IRQ_CLR);

   // control fields
   wire rx_sel = ctrl_q[B_RXSEL];
   wire tx_sel = ctrl_q[B_TXSEL];
   wire exen   = ctrl_q[B_EXEN];
   wire run    = ctrl_q[B_RUN];
   wire csel   = ctrl_q[B_CSEL];
   wire cprl   = ctrl_q[B_CPRL];
   wire uden   = mode_q[B_UDEN];
   wire baud   = rx_sel | tx_sel;

   // count sources
   wire int_tick;
   wire pin_fall;
   wire trig_fall;

   t2cl_prescale u_pre (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .run_i      (run),
      .div_i      (baud ? DIV_BAUD : DIV_TIMER),
      .tick_o     (int_tick)
   );

   t2cl_edge u_cnt_edge (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .pin_i      (count_input_pin_i),
      .fall_o     (pin_fall)
   );

   t2cl_edge u_trig_edge (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .pin_i      (external_trigger_pin_i),
      .fall_o     (trig_fall)
   );

   wire src_tick = csel ? pin_fall : int_tick;
   wire step     = run & src_tick;
   wire ovf      = step & (cnt_q == CNT_MAX);
   // trigger only when enabled, not baud
   wire trig     = exen & ~baud & trig_fall;
   // reload on overflow or trigger, else capture
   wire do_cap   = trig & cprl;
   wire do_rld   = (ovf & (baud | ~cprl)) | (trig & ~cprl);
   wire set_ovf  = ovf & ~baud;
   wire set_exf  = trig;

   // sequencer follows run and baud mode
   always_comb
   begin
      case (state_q)
         T2CL_IDLE:  state_d = !run ? T2CL_IDLE : (baud ? T2CL_BAUD : T2CL_COUNT);
         T2CL_COUNT: state_d = !run ? T2CL_IDLE : (baud ? T2CL_BAUD : T2CL_COUNT);
         T2CL_BAUD:  state_d = !run ? T2CL_IDLE : (baud ? T2CL_BAUD : T2CL_COUNT);
         default:    state_d = T2CL_IDLE;
      endcase
   end

   // control byte, bitwise set and clear
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (wr_ctrl)
      begin
         ctrl_d = wdata_i;
      end
      if (wr_set)
      begin
         ctrl_d = ctrl_q | wdata_i;
      end
      if (wr_clr)
      begin
         ctrl_d = ctrl_q & ~wdata_i;
      end
      // hardware set wins over software clear
      ctrl_d[B_OVF] = ctrl_d[B_OVF] | set_ovf;
      ctrl_d[B_EXF] = ctrl_d[B_EXF] | set_exf;
   end

   always_comb
   begin
      cnt_d = cnt_q;
      if (do_rld)
      begin
         cnt_d = cap_q;
      end
      else if (step)
      begin
         cnt_d = cnt_q + 16'h0001;
      end
      if (wr_cnt_lo)
      begin
         cnt_d[7:0] = wdata_i;
      end
      if (wr_cnt_hi)
      begin
         cnt_d[15:8] = wdata_i;
      end
   end

   always_comb
   begin
      cap_d = cap_q;
      if (do_cap)
      begin
         cap_d = cnt_q;
      end
      if (wr_cap_lo)
      begin
         cap_d[7:0] = wdata_i;
      end
      if (wr_cap_hi)
      begin
         cap_d[15:8] = wdata_i;
      end
   end

   // sticky interrupt status, write one clears
   always_comb
   begin
      istat_d[I_OVF] = sticky(istat_q[I_OVF], set_ovf, wr_iclr & wdata_i[I_OVF]);
      istat_d[I_EXF] = sticky(istat_q[I_EXF], set_exf, wr_iclr & wdata_i[I_EXF]);
   end

   // read mux
   logic [7:0] rd_mux;
   always_comb
   begin
      case (addr_i)
         OFS_CTRL:     rd_mux = ctrl_q;
         OFS_MODE:     rd_mux = {6'h00, mode_q};
         OFS_CNT_LO:   rd_mux = cnt_q[7:0];
         OFS_CNT_HI:   rd_mux = cnt_q[15:8];
         OFS_CAP_LO:   rd_mux = cap_q[7:0];
         OFS_CAP_HI:   rd_mux = cap_q[15:8];
         OFS_IRQ_STAT: rd_mux = {6'h00, istat_q};
         OFS_IRQ_EN:   rd_mux = {6'h00, ien_q};
         default:      rd_mux = RD_IDLE;
      endcase
   end

   wire smode_ok = (serial_mode_i == SMODE_1) || (serial_mode_i == SMODE_3);
   wire rx_src   = rx_sel ? ovf : t1_ovf_i;
   wire tx_src   = tx_sel ? ovf : t1_ovf_i;
   wire timer_req = ctrl_d[B_OVF] | (ctrl_d[B_EXF] & ~uden);
   wire irq_req   = |(istat_d & ien_q & {~uden, 1'b1});

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_q  <= CTRL_RST;
         mode_q  <= MODE_RST[1:0];
         cnt_q   <= CNT_RST;
         cap_q   <= CNT_RST;
         istat_q <= 2'h0;
         ien_q   <= 2'h0;
         state_q <= T2CL_IDLE;
      end
      else
      begin
         ctrl_q  <= ctrl_d;
         cnt_q   <= cnt_d;
         cap_q   <= cap_d;
         istat_q <= istat_d;
         state_q <= state_d;
         if (wr_mode)
         begin
            mode_q <= {wdata_i[B_CLKOE], wdata_i[B_UDEN]};
         end
         if (wr_ien)
         begin
            ien_q <= wdata_i[1:0];
         end
      end
   end

   // registered outputs
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_o     <= RD_IDLE;
         rx_baud_o   <= 1'b0;
         tx_baud_o   <= 1'b0;
         timer_irq_o <= 1'b0;
         irq_o       <= 1'b0;
      end
      else
      begin
         rdata_o     <= rd_i ? rd_mux : RD_IDLE;
         rx_baud_o   <= smode_ok & rx_src;
         tx_baud_o   <= smode_ok & tx_src;
         timer_irq_o <= timer_int_en_i & timer_req;
         irq_o       <= irq_req;
      end
   end
endmodule

/* File: t2cl_timer2_assertions.sv */
// port checks for the timer two control logic
module t2cl_timer2_assertions
   import t2cl_pkg::*;
(
   input wire logic          core_clk_i,             // clk
   input wire logic          rst_i,                  // reset
   input wire logic [AW-1:0] addr_i,                 // addr
   input wire logic [DW-1:0] wdata_i,                // data
   input wire logic          wr_i,                   // write
   input wire logic          rd_i,                   // read
   input wire logic [DW-1:0] rdata_o,                // rdata
   input wire logic          count_input_pin_i,      // pin
   input wire logic          external_trigger_pin_i, // pin
   input wire logic          t1_ovf_i,               // t1
   input wire logic [1:0]    serial_mode_i,          // mode
   input wire logic          timer_int_en_i,         // ie
   input wire logic          rx_baud_o,              // rx
   input wire logic          tx_baud_o,              // tx
   input wire logic          timer_irq_o,            // vector
   input wire logic          irq_o                   // irq
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   property p_rst; $fell(rst_i) |-> !irq_o && !timer_irq_o && rdata_o == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("busy after reset");
   property p_rdz; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
   a_rdz: assert property (p_rdz) else $error("stray read data");
   property p_ien; !timer_int_en_i |=> !timer_irq_o; endproperty
   a_ien: assert property (p_ien) else $error("vector while disabled");
   property p_ihold; timer_irq_o && timer_int_en_i && !wr_i && !$past(wr_i) |=> timer_irq_o; endproperty
   a_ihold: assert property (p_ihold) else $error("vector dropped");
   property p_istk; irq_o && !wr_i && !$past(wr_i) |=> irq_o; endproperty
   a_istk: assert property (p_istk) else $error("irq dropped");
   property p_rxg; !serial_mode_i[0] |=> !rx_baud_o; endproperty
   a_rxg: assert property (p_rxg) else $error("rx baud in mode");
   property p_txg; tx_baud_o |-> $past(serial_mode_i[0]); endproperty
   a_txg: assert property (p_txg) else $error("tx baud in mode");
   property p_rxp; rx_baud_o && !t1_ovf_i && !wr_i |=> !rx_baud_o; endproperty
   a_rxp: assert property (p_rxp) else $error("rx baud too long");
   c_vec: cover property (timer_irq_o);
   c_irq: cover property (irq_o);
   c_rx: cover property (rx_baud_o);
endmodule

/* File: t2cl_pin_model.sv */
// far side pins: count input and trigger, idle high
module t2cl_pin_model (
   input  wire logic core_clk_i,  // clk
   output logic      count_pin_o, // count
   output logic      trig_pin_o   // trigger
);
   timeunit 1ns;
   timeprecision 1ns;
   initial count_pin_o = 1'b1;
   initial trig_pin_o = 1'b1;
   // one fall, low for lo cycles
   task automatic fall(input bit trig, input int lo);
      if (trig)
         trig_pin_o <= 1'b0;
      else
         count_pin_o <= 1'b0;
      repeat (lo) @(posedge core_clk_i);
      trig_pin_o <= 1'b1;
      count_pin_o <= 1'b1;
      repeat (2) @(posedge core_clk_i);
   endtask
endmodule

/* File: t2cl_timer2_tb.sv */
// self-checking bench for the timer two control logic
module t2cl_timer2_tb
   import t2cl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       ws = 1'b0;
   logic       rs = 1'b0;
   logic       t1 = 1'b0;
   logic       ie = 1'b0;
   logic [7:0] ad = 8'h00;
   logic [7:0] wd = 8'h00;
   logic [1:0] sm = 2'h0;
   logic [7:0] rdata;
   logic       cp;
   logic       tp;
   logic       rxb;
   logic       txb;
   logic       virq;
   logic       irq;
   int         fail_count = 0;
   int         checked = 0;
   int         rxn = 0;
   int         txn = 0;
   always #10 clk = ~clk;
   always @(posedge clk)
   begin
      rxn <= rxn + int'(rxb === 1'b1);
      txn <= txn + int'(txb === 1'b1);
   end
   t2cl_timer2 dut (.core_clk_i(clk), .rst_i(rst), .addr_i(ad), .wdata_i(wd),
      .wr_i(ws), .rd_i(rs), .rdata_o(rdata), .count_input_pin_i(cp),
      .external_trigger_pin_i(tp), .t1_ovf_i(t1), .serial_mode_i(sm),
      .timer_int_en_i(ie), .rx_baud_o(rxb), .tx_baud_o(txb),
      .timer_irq_o(virq), .irq_o(irq));
   t2cl_pin_model pins (.core_clk_i(clk), .count_pin_o(cp), .trig_pin_o(tp));
   task automatic complete_run;
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      ad <= a;
      wd <= d;
      ws <= 1'b1;
      @(posedge clk);
      ws <= 1'b0;
      // idle edge so a following write never re-raises the strobe in this step
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      ad <= a;
      rs <= 1'b1;
      @(posedge clk);
      rs <= 1'b0;
      @(negedge clk);
      chk(rdata, e);
      @(posedge clk);
   endtask
   // registered level, two cycles on; vec picks vector request or irq
   task automatic late(input bit vec, input logic e);
      repeat (2) @(negedge clk);
      chk({7'h00, (vec ? virq : irq)}, {7'h00, e});
      @(posedge clk);
   endtask
   task automatic t_regs;
      rd(OFS_CTRL, 8'h00);
      rd(OFS_MODE, 8'h00);
      rd(8'h10, 8'h00);
      wr(OFS_CTRL_SET, 8'h0F);
      wr(OFS_CTRL_CLR, 8'h05);
      rd(OFS_CTRL, 8'h0A);
      pins.fall(1'b0, 2);
      rd(OFS_CNT_LO, 8'h00);
   endtask
   task automatic t_capture;
      wr(OFS_CNT_LO, 8'h00);
      wr(OFS_CNT_HI, 8'h00);
      wr(OFS_CTRL, 8'h0F);
      repeat (5) pins.fall(1'b0, 2);
      pins.fall(1'b1, 3);
      rd(OFS_CAP_LO, 8'h05);
      rd(OFS_CTRL, 8'h4F);
      rd(OFS_IRQ_STAT, 8'h02);
      wr(OFS_IRQ_CLR, 8'h02);
      ie <= 1'b1;
      late(1'b1, 1'b1);
      wr(OFS_MODE, 8'h01);
      late(1'b1, 1'b0);
      wr(OFS_MODE, 8'h00);
   endtask
   task automatic t_trig_off;
      // internal source: one step every twelve clocks
      wr(OFS_CTRL, 8'h00);
      wr(OFS_CNT_LO, 8'h00);
      wr(OFS_CTRL, 8'h04);
      repeat (30) @(posedge clk);
      rd(OFS_CNT_LO, 8'h02);
      wr(OFS_CTRL, 8'h07);
      pins.fall(1'b1, 2);
      rd(OFS_CTRL, 8'h07);
      rd(OFS_CAP_LO, 8'h05);
   endtask
   task automatic t_reload;
      wr(OFS_CAP_LO, 8'hFE);
      wr(OFS_CAP_HI, 8'hFF);
      wr(OFS_CNT_LO, 8'hFE);
      wr(OFS_CNT_HI, 8'hFF);
      wr(OFS_CTRL, 8'h06);
      repeat (2) pins.fall(1'b0, 1);
      rd(OFS_CTRL, 8'h86);
      rd(OFS_CNT_LO, 8'hFE);
      rd(OFS_IRQ_STAT, 8'h01);
      wr(OFS_IRQ_EN, 8'h01);
      late(1'b0, 1'b1);
      wr(OFS_IRQ_EN, 8'h00);
      late(1'b0, 1'b0);
      wr(OFS_IRQ_EN, 8'h01);
      wr(OFS_IRQ_CLR, 8'h01);
      late(1'b0, 1'b0);
   endtask
   task automatic t_baud;
      int r;
      int t;
      r = rxn;
      t = txn;
      wr(OFS_CTRL, 8'h20);
      t1 <= 1'b1;
      @(posedge clk);
      t1 <= 1'b0;
      sm <= SMODE_1;
      repeat (3) @(posedge clk);
      chk(8'(txn - t), 8'h00);
      t1 <= 1'b1;
      @(posedge clk);
      t1 <= 1'b0;
      repeat (3) @(posedge clk);
      chk(8'(txn - t), 8'h01);
      chk(8'(rxn - r), 8'h00);
      wr(OFS_CNT_LO, 8'hFF);
      wr(OFS_CNT_HI, 8'hFF);
      wr(OFS_CAP_LO, 8'h34);
      wr(OFS_CAP_HI, 8'h12);
      wr(OFS_CTRL, 8'h3F);
      pins.fall(1'b0, 2);
      repeat (2) @(posedge clk);
      chk(8'(rxn - r), 8'h01);
      chk(8'(txn - t), 8'h02);
      pins.fall(1'b1, 2);
      rd(OFS_CTRL, 8'h3F);
      rd(OFS_CAP_LO, 8'h34);
      rd(OFS_CNT_LO, 8'h34);
      rd(OFS_CNT_HI, 8'h12);
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_capture();
      t_trig_off();
      t_reload();
      t_baud();
      complete_run();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      $display("[FAIL] %0t run timed out", $time);
      complete_run();
   end
endmodule
bind t2cl_timer2 t2cl_timer2_assertions u_chk (.*);
